// [core/can_diag_pkg.sv]
package can_diag_pkg;
    // timing base
    localparam int CLK_HZ     = 20_000_000;
    localparam int CLK_NS     = 1_000_000_000 / CLK_HZ;
    localparam int WIN_NS     = 1000;
    localparam int WIN_CYC    = WIN_NS / CLK_NS;
    localparam int TXTO_US    = 1000;
    localparam int TXTO_CYC   = (TXTO_US * 1000) / CLK_NS;
    localparam int TXREC_US   = 32;
    localparam int TXREC_CYC  = (TXREC_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_US    = 16;
    localparam int WAKE_CYC   = (WAKE_US * 1000 + CLK_NS - 1) / CLK_NS;
    // open wire counter
    localparam logic [2:0] OW_LIMIT = 3'h4;
    // register indices, byte address is four times the index
    localparam logic [2:0] IDX_RCR = 3'h1;
    localparam logic [2:0] IDX_CAN = 3'h2;
    localparam logic [2:0] IDX_IOR = 3'h3;
    // field positions
    localparam int RCR_TXF_BIT   = 1;
    localparam int RCR_WU_BIT    = 2;
    localparam int CAN_MODE_LSB  = 0;
    localparam int CAN_OWH_BIT   = 2;
    localparam int CAN_OWL_BIT   = 3;
    localparam int IOR_SEL_LSB   = 0;
    localparam int IOR_SHIFT_BIT = 2;
    // reset values
    localparam logic [1:0] CAN_MODE_RST = 2'h0;
    localparam logic [1:0] IOR_SEL_RST  = 2'h0;
    // system modes, driven by the mode logic
    localparam logic [2:0] SYS_NORMAL  = 3'h1;
    localparam logic [2:0] SYS_STANDBY = 3'h2;
    localparam logic [2:0] SYS_STOP    = 3'h3;
    localparam logic [2:0] SYS_SLEEP   = 3'h4;

    typedef enum logic [1:0] {
        CAN_TXRX   = 2'b00,
        CAN_RXONLY = 2'b01,
        CAN_TERM   = 2'b10
    } can_mode_t;

    typedef enum logic {
        TX_OK    = 1'b0,
        TX_STUCK = 1'b1
    } tx_state_t;
endpackage

// [core/can_fault_diagnostics.sv]
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/1ns
module can_fault_diagnostics #(
    parameter int TXTO_CYCLES = can_diag_pkg::TXTO_CYC,
    parameter bit VARIANT_TWO = 1'b1
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // system mode
    input  wire logic [2:0]  sys_mode,
    // pins and comparators, asynchronous
    input  wire logic        tx_in,
    input  wire logic        diff_rx_in,
    input  wire logic        se_h_in,
    input  wire logic        se_l_in,
    input  wire logic        wake_h_in,
    input  wire logic        wake_l_in,
    input  wire logic [3:0]  gnd_below_in,
    // outputs
    output logic             rx_out,
    output logic             bus_drv_en,
    output logic             rx_path_en,
    output logic             int_pulse,
    output logic             nreq_pulse
);

    ////////////////////////////////////////////////////////////////////////
    // synchronisers: stage one is read only by stage two
    logic [9:0] sync1_ff;
    logic [9:0] sync2_ff;
    logic [9:0] prev_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_ff <= 10'h3c0;
            sync2_ff <= 10'h3c0;
            prev_ff  <= 10'h3c0;
        end else begin
            sync1_ff <= {tx_in, diff_rx_in, se_h_in, se_l_in,
                         wake_h_in, wake_l_in, gnd_below_in};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    logic       tx_s;
    logic       diff_s;
    logic       seh_s;
    logic       sel_s;
    logic       wake_dom;
    logic [3:0] gnd_s;
    logic       tx_fall;
    logic       diff_fall;

    assign tx_s      = sync2_ff[9];
    assign diff_s    = sync2_ff[8];
    assign seh_s     = sync2_ff[7];
    assign sel_s     = sync2_ff[6];
    assign wake_dom  = sync2_ff[5] | sync2_ff[4];
    assign gnd_s     = sync2_ff[3:0];
    assign tx_fall   = prev_ff[9] & ~tx_s;
    assign diff_fall = prev_ff[8] & ~diff_s;

    ////////////////////////////////////////////////////////////////////////
    // avalon slave, one wait state on every access
    logic [1:0] can_mode_ff;
    logic [1:0] gnd_sel_ff;
    logic       tx_stuck_flag_ff;
    logic       bus_wake_flag_ff;
    logic       shift_flag_ff;
    logic       ow_h_ff;
    logic       ow_l_ff;
    logic       wr_go;
    logic       rd_go;
    logic [2:0] idx;

    assign idx   = avs_address[4:2];
    assign wr_go = avs_write & ~avs_waitrequest;
    assign rd_go = avs_read & ~avs_waitrequest;

    always_ff @(posedge clk) begin
        if (srst)
            avs_waitrequest <= 1'b1;
        else if ((avs_read | avs_write) & avs_waitrequest)
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            avs_readdata <= 32'h0;
        end else if (avs_read & avs_waitrequest) begin
            case (idx)
                can_diag_pkg::IDX_RCR: begin
                    avs_readdata <= 32'h0;
                    avs_readdata[can_diag_pkg::RCR_TXF_BIT] <= tx_stuck_flag_ff;
                    avs_readdata[can_diag_pkg::RCR_WU_BIT]  <= bus_wake_flag_ff;
                end
                can_diag_pkg::IDX_CAN: begin
                    avs_readdata <= 32'h0;
                    avs_readdata[can_diag_pkg::CAN_MODE_LSB +: 2] <= can_mode_ff;
                    avs_readdata[can_diag_pkg::CAN_OWH_BIT] <= ow_h_ff;
                    avs_readdata[can_diag_pkg::CAN_OWL_BIT] <= ow_l_ff;
                end
                can_diag_pkg::IDX_IOR: begin
                    avs_readdata <= 32'h0;
                    avs_readdata[can_diag_pkg::IOR_SEL_LSB +: 2] <= gnd_sel_ff;
                    avs_readdata[can_diag_pkg::IOR_SHIFT_BIT] <= shift_flag_ff;
                end
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            can_mode_ff <= can_diag_pkg::CAN_MODE_RST;
            gnd_sel_ff  <= can_diag_pkg::IOR_SEL_RST;
        end else if (wr_go) begin
            if (idx == can_diag_pkg::IDX_CAN)
                can_mode_ff <= avs_writedata[can_diag_pkg::CAN_MODE_LSB +: 2];
            if (idx == can_diag_pkg::IDX_IOR)
                gnd_sel_ff <= avs_writedata[can_diag_pkg::IOR_SEL_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interface mode; low-power system modes force battery termination
    logic term;
    logic low_pwr;
    logic awake_mode;

    assign low_pwr    = (sys_mode == can_diag_pkg::SYS_SLEEP) |
                        (sys_mode == can_diag_pkg::SYS_STOP);
    assign term       = low_pwr | (can_mode_ff == can_diag_pkg::CAN_TERM);
    assign awake_mode = (sys_mode == can_diag_pkg::SYS_NORMAL) |
                        (sys_mode == can_diag_pkg::SYS_STANDBY);

    ////////////////////////////////////////////////////////////////////////
    // transmit stuck dominant
    can_diag_pkg::tx_state_t tx_state_ff;
    logic [15:0] tx_cnt_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            tx_state_ff <= can_diag_pkg::TX_OK;
            tx_cnt_ff   <= 16'h0;
        end else begin
            case (tx_state_ff)
                can_diag_pkg::TX_OK: begin
                    if (tx_s)
                        tx_cnt_ff <= 16'h0;
                    else if (tx_cnt_ff == 16'(TXTO_CYCLES - 1)) begin
                        tx_state_ff <= can_diag_pkg::TX_STUCK;
                        tx_cnt_ff   <= 16'h0;
                    end else
                        tx_cnt_ff <= tx_cnt_ff + 16'h1;
                end
                can_diag_pkg::TX_STUCK: begin
                    if (!tx_s)
                        tx_cnt_ff <= 16'h0;
                    else if (tx_cnt_ff == 16'(can_diag_pkg::TXREC_CYC - 1)) begin
                        tx_state_ff <= can_diag_pkg::TX_OK;
                        tx_cnt_ff   <= 16'h0;
                    end else
                        tx_cnt_ff <= tx_cnt_ff + 16'h1;
                end
                default: begin
                    tx_state_ff <= can_diag_pkg::TX_OK;
                    tx_cnt_ff   <= 16'h0;
                end
            endcase
        end
    end

    logic tx_stuck_set;
    assign tx_stuck_set = (tx_state_ff == can_diag_pkg::TX_OK) & ~tx_s &
                          (tx_cnt_ff == 16'(TXTO_CYCLES - 1));

    logic rcr_read;
    assign rcr_read = rd_go & (idx == can_diag_pkg::IDX_RCR);

    // flags clear on read; a set in the same cycle wins
    always_ff @(posedge clk) begin
        if (srst)
            tx_stuck_flag_ff <= 1'b0;
        else if (tx_stuck_set)
            tx_stuck_flag_ff <= 1'b1;
        else if (rcr_read)
            tx_stuck_flag_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // open wire: sample window after each recessive-to-dominant switch
    logic [4:0] win_cnt_ff;
    logic       win_act_ff;
    logic       win_end;
    logic [2:0] ow_cnt_h_ff;
    logic [2:0] ow_cnt_l_ff;

    assign win_end = win_act_ff & (win_cnt_ff == 5'(can_diag_pkg::WIN_CYC - 1));

    // own transmission aborts the window; only foreign frames count
    always_ff @(posedge clk) begin
        if (srst) begin
            win_act_ff <= 1'b0;
            win_cnt_ff <= 5'h0;
        end else if (term | ~tx_s) begin
            win_act_ff <= 1'b0;
            win_cnt_ff <= 5'h0;
        end else if (diff_fall & ~win_act_ff) begin
            win_act_ff <= 1'b1;
            win_cnt_ff <= 5'h0;
        end else if (win_end) begin
            win_act_ff <= 1'b0;
        end else if (win_act_ff) begin
            win_cnt_ff <= win_cnt_ff + 5'h1;
        end
    end

    function automatic logic [3:0] ow_next(input logic [2:0] cnt, input logic ow, input logic dom);
        logic [2:0] c;
        logic       o;
        c = cnt;
        o = ow;
        if (!ow) begin
            if (!dom) begin
                c = cnt + 3'h1;
                if (c == can_diag_pkg::OW_LIMIT)
                    o = 1'b1;
            end else if (cnt != 3'h0)
                c = cnt - 3'h1;
        end else if (dom) begin
            c = cnt - 3'h1;
            if (c == 3'h0)
                o = 1'b0;
        end else if (VARIANT_TWO && cnt != can_diag_pkg::OW_LIMIT)
            c = cnt + 3'h1;
        return {o, c};
    endfunction

    // a recessive sample on a wire is a detection pulse, dominant a recovery
    always_ff @(posedge clk) begin
        if (srst) begin
            {ow_h_ff, ow_cnt_h_ff} <= 4'h0;
            {ow_l_ff, ow_cnt_l_ff} <= 4'h0;
        end else if (win_end & tx_s & ~term) begin
            {ow_h_ff, ow_cnt_h_ff} <= ow_next(ow_cnt_h_ff, ow_h_ff, seh_s);
            {ow_l_ff, ow_cnt_l_ff} <= ow_next(ow_cnt_l_ff, ow_l_ff, sel_s);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wake filter on the bus wake comparators
    logic [8:0] wake_cnt_ff;
    logic       wake_filt_ff;
    logic       wake_evt;

    always_ff @(posedge clk) begin
        if (srst) begin
            wake_cnt_ff  <= 9'h0;
            wake_filt_ff <= 1'b0;
        end else if (!term || !wake_dom) begin
            wake_cnt_ff  <= 9'h0;
            wake_filt_ff <= 1'b0;
        end else if (wake_cnt_ff == 9'(can_diag_pkg::WAKE_CYC - 1)) begin
            wake_filt_ff <= 1'b1;
        end else begin
            wake_cnt_ff <= wake_cnt_ff + 9'h1;
        end
    end

    assign wake_evt = term & wake_dom & ~wake_filt_ff &
                      (wake_cnt_ff == 9'(can_diag_pkg::WAKE_CYC - 1));

    always_ff @(posedge clk) begin
        if (srst)
            bus_wake_flag_ff <= 1'b0;
        else if (wake_evt & low_pwr)
            bus_wake_flag_ff <= 1'b1;
        else if (rcr_read)
            bus_wake_flag_ff <= 1'b0;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            nreq_pulse <= 1'b0;
            int_pulse  <= 1'b0;
        end else begin
            nreq_pulse <= wake_evt & (sys_mode == can_diag_pkg::SYS_SLEEP);
            int_pulse  <= wake_evt & (sys_mode == can_diag_pkg::SYS_STOP);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ground shift, sampled raw on every transmit falling edge
    logic ior_read;
    assign ior_read = rd_go & (idx == can_diag_pkg::IDX_IOR);

    // single trials are noisy; software is expected to repeat them
    always_ff @(posedge clk) begin
        if (srst)
            shift_flag_ff <= 1'b0;
        else if (tx_fall & gnd_s[gnd_sel_ff])
            shift_flag_ff <= 1'b1;
        else if (ior_read)
            shift_flag_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // pin side; open wire state deliberately feeds none of this
    always_ff @(posedge clk) begin
        if (srst) begin
            bus_drv_en <= 1'b0;
            rx_path_en <= 1'b0;
            rx_out     <= 1'b1;
        end else begin
            bus_drv_en <= ~term & (can_mode_ff == can_diag_pkg::CAN_TXRX) &
                          (tx_state_ff == can_diag_pkg::TX_OK);
            rx_path_en <= ~term;
            if (!term)
                rx_out <= diff_s;
            else if (VARIANT_TWO && awake_mode)
                rx_out <= ~wake_filt_ff;
            else
                rx_out <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_open_wire_no_effect: assert property (@(posedge clk) disable iff (srst)
        $rose(ow_h_ff) |-> $stable(bus_drv_en) && $stable(rx_path_en))
        else $error("open wire changed a path enable");
    a_window_length: assert property (@(posedge clk) disable iff (srst)
        $rose(win_act_ff) && tx_s && !term |-> (win_act_ff && tx_s && !term) [*8] ##12 win_end)
        else $error("sample window not 1 us");
    a_count_suspended: assert property (@(posedge clk) disable iff (srst)
        !tx_s |=> $stable(ow_cnt_h_ff) && $stable(ow_cnt_l_ff))
        else $error("counter moved while transmitting");
    a_detect_at_four: assert property (@(posedge clk) disable iff (srst)
        $rose(ow_h_ff) |-> ow_cnt_h_ff == 3'h4 && $past(ow_cnt_h_ff) == 3'h3)
        else $error("open wire not declared at 4");
    a_recover_at_zero: assert property (@(posedge clk) disable iff (srst)
        $fell(ow_l_ff) |-> ow_cnt_l_ff == 3'h0)
        else $error("recovery before zero");
    a_stuck_drivers_off: assert property (@(posedge clk) disable iff (srst)
        tx_stuck_set |=> tx_stuck_flag_ff ##1 !bus_drv_en)
        else $error("stuck transmit did not disable drivers");
    a_stuck_recovery: assert property (@(posedge clk) disable iff (srst)
        $fell(tx_state_ff) |-> $past(tx_s) && tx_cnt_ff == 16'h0)
        else $error("stuck cleared without recessive time");

    a_rx_follows_wake: assert property (@(posedge clk) disable iff (srst)
        term && awake_mode && wake_filt_ff |=> !rx_out || !term || !awake_mode)
        else $error("receive not low for filtered dominant");

    a_sleep_wake: assert property (@(posedge clk) disable iff (srst)
        wake_evt && sys_mode == can_diag_pkg::SYS_SLEEP |=> nreq_pulse && bus_wake_flag_ff ##1 !nreq_pulse)
        else $error("sleep wake not handled");

    a_shift_sets: assert property (@(posedge clk) disable iff (srst)
        tx_fall && gnd_s[gnd_sel_ff] |=> shift_flag_ff)
        else $error("ground shift flag not set");

endmodule // can_fault_diagnostics

// [verif/can_bus_model.sv]
`timescale 1ns/1ns
// protocol controller, remote nodes and bus comparators
module can_bus_model (
    // clock
    input  wire logic       clk,
    // pins toward the block
    output logic            tx_in,
    output logic            diff_rx_in,
    output logic            se_h_in,
    output logic            se_l_in,
    output logic            wake_h_in,
    output logic            wake_l_in,
    output logic [3:0]      gnd_below_in
);
    initial begin
        tx_in        = 1'b1;
        diff_rx_in   = 1'b1;
        se_h_in      = 1'b0;
        se_l_in      = 1'b0;
        wake_h_in    = 1'b0;
        wake_l_in    = 1'b0;
        gnd_below_in = 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic set_tx(input logic v);
        tx_in <= v;
    endtask
    task automatic set_wake(input logic h, input logic l);
        wake_h_in <= h;
        wake_l_in <= l;
    endtask
    // one dominant bit; h and l say which wire still carries it, own means we send it
    task automatic dom_bit(input logic h, input logic l, input logic own);
        diff_rx_in <= 1'b0;
        se_h_in    <= h;
        se_l_in    <= l;
        tx_in      <= ~own;
        idle(40);
        diff_rx_in <= 1'b1;
        se_h_in    <= 1'b0;
        se_l_in    <= 1'b0;
        tx_in      <= 1'b1;
        idle(40);
    endtask
    // comparators settle well before the transmit edge, as on the real bus
    task automatic gnd_edge(input logic [3:0] v);
        gnd_below_in <= v;
        idle(4);
        tx_in <= 1'b0;
        idle(6);
        tx_in <= 1'b1;
        idle(6);
        gnd_below_in <= 4'h0;
    endtask
endmodule // can_bus_model

// [verif/tb.sv]
`timescale 1ns/1ns
module tb;
    logic        clk;
    logic        srst;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  sys_mode;
    logic        tx_in, diff_rx_in, se_h_in, se_l_in, wake_h_in, wake_l_in;
    logic [3:0]  gnd_below_in;
    logic        rx_out, bus_drv_en, rx_path_en, int_pulse, nreq_pulse;
    int          fail_count;
    int          n_tests;
    int          cyc;
    localparam logic [4:0] A_RCR = {can_diag_pkg::IDX_RCR, 2'h0};
    localparam logic [4:0] A_CAN = {can_diag_pkg::IDX_CAN, 2'h0};
    localparam logic [4:0] A_IOR = {can_diag_pkg::IDX_IOR, 2'h0};
    localparam logic [31:0] TXF = 32'h1 << can_diag_pkg::RCR_TXF_BIT;
    localparam logic [31:0] WUF = 32'h1 << can_diag_pkg::RCR_WU_BIT;
    localparam logic [31:0] OWH = 32'h1 << can_diag_pkg::CAN_OWH_BIT;
    localparam logic [31:0] OWL = 32'h1 << can_diag_pkg::CAN_OWL_BIT;
    localparam logic [31:0] SHF = 32'h1 << can_diag_pkg::IOR_SHIFT_BIT;

    can_bus_model i_bus (.clk(clk), .tx_in(tx_in), .diff_rx_in(diff_rx_in), .se_h_in(se_h_in),
        .se_l_in(se_l_in), .wake_h_in(wake_h_in), .wake_l_in(wake_l_in), .gnd_below_in(gnd_below_in));
    // short timeout keeps the stuck-transmit run brief
    can_fault_diagnostics #(.TXTO_CYCLES(100), .VARIANT_TWO(1'b1)) i_dut (.clk(clk), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sys_mode(sys_mode), .tx_in(tx_in), .diff_rx_in(diff_rx_in), .se_h_in(se_h_in),
        .se_l_in(se_l_in), .wake_h_in(wake_h_in), .wake_l_in(wake_l_in), .gnd_below_in(gnd_below_in),
        .rx_out(rx_out), .bus_drv_en(bus_drv_en), .rx_path_en(rx_path_en), .int_pulse(int_pulse),
        .nreq_pulse(nreq_pulse));

    always #25 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask
    // one access; the extra edge at the end keeps back-to-back calls from
    // assigning the strobes twice in one time step
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_read      <= ~wr;
        avs_write     <= wr;
        // no local limit: a slave that never answers is caught by the cycle ceiling
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(nm, r, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("bus_drv_en", bus_drv_en, 32'h1);
        chk("rx_path_en", rx_path_en, 32'h1);
        chk("rx_idle", rx_out, 32'h1);
        // both wires dominant is a recovery pulse, so the open wire counters stay at zero
        fork
            i_bus.dom_bit(1'b1, 1'b1, 1'b0);
            begin
                i_bus.idle(20);
                chk("rx_follows_diff", rx_out, 32'h0);
            end
        join
        rd_chk("reset_control_reg", A_RCR, 32'h0);
        rd_chk("can_ctrl", A_CAN, 32'h0);
        rd_chk("io_control_reg", A_IOR, 32'h0);
        wr(5'h10, 32'h0000000f);
        rd_chk("unmapped", 5'h10, 32'h0);
        wr(A_CAN, 32'h1);
        rd_chk("can_mode", A_CAN, 32'h1);
        wr(A_CAN, 32'h2);
        i_bus.idle(3);
        chk("rx_path_term", rx_path_en, 32'h0);
        wr(A_CAN, 32'h0);
    endtask
    task automatic t_stuck();
        i_bus.set_tx(1'b0);
        i_bus.idle(90);
        chk("drv_before_timeout", bus_drv_en, 32'h1);
        i_bus.idle(20);
        chk("drv_after_timeout", bus_drv_en, 32'h0);
        rd_chk("tx_stuck_flag", A_RCR, TXF);
        i_bus.set_tx(1'b1);
        i_bus.idle(600);
        chk("drv_recovering", bus_drv_en, 32'h0);
        i_bus.idle(60);
        chk("drv_recovered", bus_drv_en, 32'h1);
        rd_chk("tx_stuck_cleared", A_RCR, 32'h0);
    endtask
    task automatic t_open();
        repeat (4) i_bus.dom_bit(1'b0, 1'b1, 1'b1);
        rd_chk("own_frame_no_count", A_CAN, 32'h0);
        repeat (3) i_bus.dom_bit(1'b0, 1'b1, 1'b0);
        rd_chk("three_not_enough", A_CAN, 32'h0);
        i_bus.dom_bit(1'b0, 1'b1, 1'b0);
        rd_chk("open_h_set", A_CAN, OWH);
        chk("drv_kept", bus_drv_en, 32'h1);
        chk("rx_kept", rx_path_en, 32'h1);
        repeat (3) i_bus.dom_bit(1'b1, 1'b1, 1'b0);
        i_bus.dom_bit(1'b0, 1'b1, 1'b0);
        repeat (3) i_bus.dom_bit(1'b0, 1'b1, 1'b0);
        repeat (3) i_bus.dom_bit(1'b1, 1'b1, 1'b0);
        rd_chk("saturated_still_open", A_CAN, OWH);
        i_bus.dom_bit(1'b1, 1'b1, 1'b0);
        rd_chk("open_h_recovered", A_CAN, 32'h0);
        repeat (4) i_bus.dom_bit(1'b1, 1'b0, 1'b0);
        rd_chk("open_l_set", A_CAN, OWL);
        chk("drv_kept_l", bus_drv_en, 32'h1);
        repeat (4) i_bus.dom_bit(1'b1, 1'b1, 1'b0);
        rd_chk("open_l_recovered", A_CAN, 32'h0);
    endtask
    // wake line held 400 cycles; filter takes 320 of them
    task automatic t_wake(input logic [2:0] m, input logic h, input logic l, input bit term_rx,
                          input int n_req, input int n_int, input logic [31:0] flag);
        int lo;
        int np;
        int ip;
        lo = 0;
        np = 0;
        ip = 0;
        sys_mode <= m;
        i_bus.idle(5);
        i_bus.set_wake(h, l);
        for (int i = 1; i <= 420; i++) begin
            @(posedge clk);
            lo += (rx_out === 1'b0);
            np += (nreq_pulse === 1'b1);
            ip += (int_pulse === 1'b1);
            if (i == 400) begin
                i_bus.set_wake(1'b0, 1'b0);
            end
        end
        i_bus.idle(20);
        chk("rx_low_cycles", (lo >= 76 && lo <= 84) ? 32'h1 : 32'h0, term_rx ? 32'h1 : 32'h0);
        chk("nreq_pulses", np, n_req);
        chk("int_pulses", ip, n_int);
        rd_chk("bus_wake_flag", A_RCR, flag);
    endtask
    task automatic t_shift();
        for (int s = 0; s < 4; s++) begin
            wr(A_IOR, 32'(s));
            i_bus.gnd_edge(4'h1 << s);
            rd_chk("shift_set", A_IOR, SHF | 32'(s));
            rd_chk("shift_read_clear", A_IOR, 32'(s));
            i_bus.gnd_edge(~(4'h1 << s));
            rd_chk("shift_other_level", A_IOR, 32'(s));
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk           = 1'b0;
        srst          = 1'b1;
        avs_address   = 5'h00;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
        sys_mode      = can_diag_pkg::SYS_NORMAL;
        fail_count    = 0;
        n_tests       = 0;
        cyc           = 0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        i_bus.idle(5);
        t_reset();
        t_stuck();
        t_open();
        wr(A_CAN, 32'h2);
        t_wake(can_diag_pkg::SYS_NORMAL, 1'b1, 1'b1, 1'b1, 0, 0, 32'h0);
        t_wake(can_diag_pkg::SYS_STANDBY, 1'b0, 1'b1, 1'b1, 0, 0, 32'h0);
        t_wake(can_diag_pkg::SYS_SLEEP, 1'b1, 1'b1, 1'b0, 1, 0, WUF);
        t_wake(can_diag_pkg::SYS_STOP, 1'b1, 1'b0, 1'b0, 0, 1, WUF);
        sys_mode <= can_diag_pkg::SYS_NORMAL;
        wr(A_CAN, 32'h0);
        i_bus.idle(5);
        t_shift();
        end_sim();
    end
endmodule // tb
